// ==== rtl/tpp_pkg.sv ====
package tpp_pkg;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_CTL0 = 14'hf20;
  localparam logic [13:0] IDX_CTL1 = 14'hf21;
  localparam logic [13:0] IDX_OVR = 14'hf27;
  localparam logic [13:0] IDX_SRC = 14'hf29;
  localparam logic [13:0] IDX_PER = 14'hf2a;
  localparam logic [13:0] IDX_DUTY0 = 14'hf2b;
  localparam logic [13:0] IDX_STAT = 14'hf31;

  // reset values
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [5:0] OVR_RST = 6'h00;
  localparam logic [15:0] PER_RST = 16'h00ff;
  localparam logic [15:0] DUTY_RST = 16'h0000;

  // field layout
  localparam int OVR_W = 6;
  localparam int PAIRS = 3;
  localparam int STAT_RELEASED_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_DIR_BIT = 2;
  localparam int STAT_CNT_LSB = 16;

  typedef struct packed {
    logic outputs_off_release;
    logic output_override_select;
    logic align_center;
    logic rsvd4;
    logic converter_trigger_enable;
    logic rsvd2;
    logic ready;
    logic modulator_enable;
  } tpp_ctl0_t;

  typedef struct packed {
    logic [1:0] reload_interval;
    logic independent_mode_select;
    logic pair2_invert;
    logic pair1_invert;
    logic pair0_invert;
    logic [1:0] clock_divider_code;
  } tpp_ctl1_t;

  // counting direction of the master counter
  typedef enum logic {
    TPP_UP = 1'b0,
    TPP_DOWN = 1'b1
  } tpp_dir_t;

  // terminal count for a divide or interval code of 1, 2, 4 or 8
  function automatic logic [2:0] tpp_code_limit(input logic [1:0] code);
    case (code)
      2'h0: tpp_code_limit = 3'h0;
      2'h1: tpp_code_limit = 3'h1;
      2'h2: tpp_code_limit = 3'h3;
      default: tpp_code_limit = 3'h7;
    endcase
  endfunction

endpackage

// ==== rtl/tpp_pair_out.sv ====
`timescale 1ns/1ps
`default_nettype none

module tpp_pair_out #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic indep,
  input wire logic invert,
  input wire logic ovr_sel,
  input wire logic ovr_hi,
  input wire logic ovr_lo,
  input wire logic [CNT_W-1:0] cnt,
  input wire logic [CNT_W-1:0] duty_hi,
  input wire logic [CNT_W-1:0] duty_lo,
  output logic pin_hi_q,
  output logic pin_lo_q
);

  logic act_hi;
  logic act_lo;
  logic off_hi;
  logic off_lo;

  ////////////////////////////////////////////////////////////////
  // compare, pairing and forcing
  always_comb begin
    act_hi = cnt < duty_hi;
    act_lo = indep ? (cnt < duty_lo) : ~act_hi;
    off_hi = ~run | (ovr_sel & ovr_hi);
    off_lo = ~run | (ovr_sel & ovr_lo);
  end

  ////////////////////////////////////////////////////////////////
  // polarity applied at pin
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_hi_q <= 1'b0;
      pin_lo_q <= 1'b0;
    end else begin
      pin_hi_q <= (act_hi & ~off_hi) ^ invert;
      pin_lo_q <= (act_lo & ~off_lo) ^ invert;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/tpp_pwm_ctrl.sv ====
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module tpp_pwm_ctrl
  import tpp_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_count_input,
  output logic [OVR_W-1:0] pwm_out,
  output logic pwm_drive_en,
  output logic adc_trig_o
);

  tpp_ctl0_t ctl0_q;
  tpp_ctl1_t ctl1_q;
  logic [OVR_W-1:0] ovr_q;
  logic src_ext_q;
  logic [CNT_W-1:0] per_hold_q;
  logic [CNT_W-1:0] duty_hold_q [OVR_W];
  logic [CNT_W-1:0] per_work_q;
  logic [CNT_W-1:0] duty_work_q [OVR_W];
  logic [1:0] presc_work_q;
  logic [1:0] intv_work_q;
  logic released_q;
  logic [CNT_W-1:0] cnt_q;
  tpp_dir_t dir_q;
  logic [2:0] div_cnt_q;
  logic [2:0] prd_cnt_q;
  logic ext_prev_q;
  logic [13:0] widx;
  logic wr_acc;
  logic [31:0] rd_d;
  logic in_tick;
  logic presc_tick;
  logic period_end;
  logic reload_ev;
  logic run;
  logic [OVR_W-1:0] off_lvl;

  ////////////////////////////////////////////////////////////////
  // bus decode: a write lands on the edge that sees ack high
  assign widx = wb_adr_i[15:2];
  assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd_d;
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    rd_d = 32'h00000000;
    case (widx)
      IDX_CTL0: rd_d[7:0] = ctl0_q;
      IDX_CTL1: rd_d[7:0] = ctl1_q;
      IDX_OVR: rd_d[OVR_W-1:0] = ovr_q;
      IDX_SRC: rd_d[0] = src_ext_q;
      IDX_PER: rd_d[CNT_W-1:0] = per_hold_q;
      IDX_STAT: begin
        rd_d[STAT_RELEASED_BIT] = released_q;
        rd_d[STAT_RUN_BIT] = ctl0_q.modulator_enable;
        rd_d[STAT_DIR_BIT] = dir_q;
        rd_d[STAT_CNT_LSB +: CNT_W] = cnt_q;
      end
      default: begin
        for (int i = 0; i < OVR_W; i++) begin
          if (widx == 14'(IDX_DUTY0 + 14'(i))) begin
            rd_d[CNT_W-1:0] = duty_hold_q[i];
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // primary control register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl0_q <= CTL0_RST;
    end else if (wr_acc && widx == IDX_CTL0 && wb_sel_i[0]) begin
      ctl0_q <= wb_dat_i[7:0];
      if (ctl0_q.modulator_enable) begin
        ctl0_q.align_center <= ctl0_q.align_center;
      end
    end
  end

  // secondary control register holds the holding copies
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl1_q <= CTL1_RST;
    end else if (wr_acc && widx == IDX_CTL1 && wb_sel_i[0]) begin
      ctl1_q <= wb_dat_i[7:0];
      if (ctl0_q.modulator_enable) begin
        ctl1_q.independent_mode_select <= ctl1_q.independent_mode_select;
      end
    end
  end

  // override bits, clock source, period holding
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovr_q <= OVR_RST;
      src_ext_q <= 1'b0;
      per_hold_q <= PER_RST;
    end else if (wr_acc) begin
      if (widx == IDX_OVR && wb_sel_i[0]) begin
        ovr_q <= wb_dat_i[OVR_W-1:0];
      end
      if (widx == IDX_SRC && wb_sel_i[0]) begin
        src_ext_q <= wb_dat_i[0];
      end
      if (widx == IDX_PER) begin
        for (int b = 0; b < CNT_W / 8; b++) begin
          if (wb_sel_i[b]) begin
            per_hold_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
      end
    end
  end

  // duty holding registers, one per output
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < OVR_W; i++) begin
        duty_hold_q[i] <= DUTY_RST;
      end
    end else if (wr_acc) begin
      for (int i = 0; i < OVR_W; i++) begin
        if (widx == 14'(IDX_DUTY0 + 14'(i))) begin
          for (int b = 0; b < CNT_W / 8; b++) begin
            if (wb_sel_i[b]) begin
              duty_hold_q[i][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // input clock select and prescaler
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= external_count_input;
    end
  end

  assign in_tick = src_ext_q ? (external_count_input & ~ext_prev_q) : 1'b1;
  // divide by 1, 2, 4 or 8
  assign presc_tick = ctl0_q.modulator_enable & in_tick & (div_cnt_q == tpp_code_limit(presc_work_q));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_q <= 3'h0;
    end else if (!ctl0_q.modulator_enable || presc_tick) begin
      div_cnt_q <= 3'h0;
    end else if (in_tick) begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // master counter: edge mode wraps, center mode runs up then down
  always_comb begin
    period_end = 1'b0;
    if (presc_tick) begin
      if (!ctl0_q.align_center || per_work_q == '0) begin
        period_end = cnt_q >= per_work_q;
      end else begin
        period_end = (dir_q == TPP_DOWN) && (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1});
      end
    end
  end

  // counter held at zero while disabled
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      dir_q <= TPP_UP;
    end else if (!ctl0_q.modulator_enable) begin
      cnt_q <= '0;
      dir_q <= TPP_UP;
    end else if (period_end) begin
      cnt_q <= '0;
      dir_q <= TPP_UP;
    end else if (presc_tick) begin
      case (dir_q)
        TPP_UP: begin
          if (ctl0_q.align_center && cnt_q >= per_work_q) begin
            dir_q <= TPP_DOWN;
            cnt_q <= cnt_q - 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        TPP_DOWN: cnt_q <= cnt_q - 1'b1;
        default: dir_q <= TPP_UP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // reload after 1, 2, 4 or 8 periods
  assign reload_ev = period_end & (prd_cnt_q >= tpp_code_limit(intv_work_q));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prd_cnt_q <= 3'h0;
      intv_work_q <= 2'h0;
    end else if (!ctl0_q.modulator_enable) begin
      prd_cnt_q <= 3'h0;
    end else if (period_end) begin
      prd_cnt_q <= reload_ev ? 3'h0 : prd_cnt_q + 3'h1;
      intv_work_q <= ctl1_q.reload_interval;
    end
  end

  // one transfer when ready; else unchanged
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_work_q <= PER_RST;
      presc_work_q <= 2'h0;
      for (int i = 0; i < OVR_W; i++) begin
        duty_work_q[i] <= DUTY_RST;
      end
    end else if (reload_ev && ctl0_q.ready) begin
      per_work_q <= per_hold_q;
      presc_work_q <= ctl1_q.clock_divider_code;
      for (int i = 0; i < OVR_W; i++) begin
        duty_work_q[i] <= duty_hold_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // drop at once; regain at reload
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      released_q <= 1'b0;
    end else if (!ctl0_q.outputs_off_release) begin
      released_q <= 1'b0;
    end else if (reload_ev) begin
      released_q <= 1'b1;
    end
  end

  assign run = ctl0_q.modulator_enable & released_q & ctl0_q.outputs_off_release;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_drive_en <= 1'b0;
      adc_trig_o <= 1'b0;
    end else begin
      pwm_drive_en <= ctl0_q.modulator_enable;
      // trigger pulse gated by enable bit
      adc_trig_o <= period_end & ctl0_q.converter_trigger_enable;
    end
  end

  ////////////////////////////////////////////////////////////////
  // output stage, one per pair
  logic [PAIRS-1:0] pol;
  assign pol = {ctl1_q.pair2_invert, ctl1_q.pair1_invert, ctl1_q.pair0_invert};

  for (genvar k = 0; k < PAIRS; k++) begin : g_pair
    tpp_pair_out #(
      .CNT_W(CNT_W)
    ) u_pair (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .run(run),
      .indep(ctl1_q.independent_mode_select),
      .invert(pol[k]),
      .ovr_sel(ctl0_q.output_override_select),
      .ovr_hi(ovr_q[2*k]),
      .ovr_lo(ovr_q[2*k+1]),
      .cnt(cnt_q),
      .duty_hi(duty_work_q[2*k]),
      .duty_lo(duty_work_q[2*k+1]),
      .pin_hi_q(pwm_out[2*k]),
      .pin_lo_q(pwm_out[2*k+1])
    );
    assign off_lvl[2*k] = pol[k];
    assign off_lvl[2*k+1] = pol[k];
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_off_now;
    !ctl0_q.outputs_off_release |=> !released_q ##0 pwm_out == $past(off_lvl);
  endproperty
  a_off_now: assert property (p_off_now) else $error("outputs not forced off at once");

  property p_release_at_reload;
    $rose(released_q) |-> $past(reload_ev) && $past(ctl0_q.outputs_off_release);
  endproperty
  a_release_at_reload: assert property (p_release_at_reload) else $error("release outside reload");

  property p_override_off;
    (ctl0_q.output_override_select && ovr_q[0]) |=> pwm_out[0] == $past(ctl1_q.pair0_invert);
  endproperty
  a_override_off: assert property (p_override_off) else $error("override output not off");

  property p_trig_gate;
    adc_trig_o |-> $past(ctl0_q.converter_trigger_enable) && $past(period_end);
  endproperty
  a_trig_gate: assert property (p_trig_gate) else $error("trigger while disabled");

  property p_copy_ready;
    (reload_ev && ctl0_q.ready) |=> per_work_q == $past(per_hold_q) && duty_work_q[0] == $past(duty_hold_q[0]);
  endproperty
  a_copy_ready: assert property (p_copy_ready) else $error("holding values not copied");

  property p_keep_not_ready;
    (reload_ev && !ctl0_q.ready) |=> $stable(per_work_q) && $stable(presc_work_q);
  endproperty
  a_keep_not_ready: assert property (p_keep_not_ready) else $error("working values changed");

  property p_disabled_idle;
    !ctl0_q.modulator_enable |=> cnt_q == '0 && pwm_out == $past(off_lvl) && !adc_trig_o;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled block not idle");

  property p_reload_interval;
    reload_ev |-> prd_cnt_q == tpp_code_limit(intv_work_q);
  endproperty
  a_reload_interval: assert property (p_reload_interval) else $error("reload interval wrong");

  property p_divide_eight;
    (presc_tick && !src_ext_q && presc_work_q == 2'h3 && !reload_ev && ctl0_q.modulator_enable) |=> !presc_tick [*7];
  endproperty
  a_divide_eight: assert property (p_divide_eight) else $error("divide by eight too fast");

endmodule

`default_nettype wire

// ==== verif/tpp_gate_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// gate driver stage: tallies cycles each gate conducts and converter triggers seen
module tpp_gate_model
  import tpp_pkg::*;
(
  input wire logic core_clk,
  input wire logic clr,
  input wire logic win,
  input wire logic pwm_drive_en,
  input wire logic [OVR_W-1:0] pwm_out,
  input wire logic adc_trig_o,
  output logic [5:0][7:0] on_cnt,
  output logic [7:0] trig_cnt
);
  ////////////////////////////////////////////////////////////////////////////
  // a gate conducts only while the pins are driven as outputs
  always_ff @(posedge core_clk) begin
    if (clr) begin
      on_cnt <= '0;
      trig_cnt <= 8'h00;
    end else if (win) begin
      for (int i = 0; i < OVR_W; i++) begin
        if (pwm_drive_en && pwm_out[i]) begin
          on_cnt[i] <= on_cnt[i] + 8'h01;
        end
      end
      if (adc_trig_o) begin
        trig_cnt <= trig_cnt + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// ==== verif/three_pair_pwm_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module three_pair_pwm_control_tb
  import tpp_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [OVR_W-1:0] pwm_out;
  logic pwm_drive_en;
  logic adc_trig_o;
  logic clr = 1'b1;
  logic win = 1'b0;
  logic [5:0][7:0] on_cnt;
  logic [7:0] trig_cnt;
  logic ext_in = 1'b0;
  logic [31:0] q;
  logic [31:0] q2;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  tpp_pwm_ctrl #(.CNT_W(16)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h3), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_count_input(ext_in),
    .pwm_out(pwm_out), .pwm_drive_en(pwm_drive_en), .adc_trig_o(adc_trig_o)
  );

  tpp_gate_model gates (
    .core_clk(core_clk), .clr(clr), .win(win), .pwm_drive_en(pwm_drive_en),
    .pwm_out(pwm_out), .adc_trig_o(adc_trig_o), .on_cnt(on_cnt), .trig_cnt(trig_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    forever #2 core_clk = ~core_clk;
  end

  // external count source: one rising edge every two clock cycles
  always @(posedge core_clk) begin
    ext_in <= ~ext_in;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // classic wishbone single cycle, held until ack is sampled
  task automatic wb(input logic [13:0] idx, input logic we, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= d;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 20) begin
      num_errors++;
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    logic [31:0] r;
    wb(idx, 1'b1, d, r);
  endtask

  // poll status until the outputs are handed back
  task automatic wait_rel();
    logic [31:0] r;
    r = 32'h00000000;
    for (int i = 0; i < 200 && r[STAT_RELEASED_BIT] !== 1'b1; i++) begin
      wb(IDX_STAT, 1'b0, 32'h00000000, r);
    end
  endtask

  // count gate on-cycles and triggers over n cycles
  task automatic tally(input int n);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    win <= 1'b1;
    repeat (n) @(posedge core_clk);
    win <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic chk_on(input logic [5:0][7:0] exp);
    for (int i = 0; i < OVR_W; i++) begin
      chk("gate on cycles", {24'h000000, on_cnt[i]}, {24'h000000, exp[i]});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    // reset values and an unmapped index
    wb(IDX_CTL0, 1'b0, 32'h0, q);
    chk("ctl0 reset", q, {24'h0, CTL0_RST});
    wb(IDX_CTL1, 1'b0, 32'h0, q);
    chk("ctl1 reset", q, {24'h0, CTL1_RST});
    wb(IDX_OVR, 1'b0, 32'h0, q);
    chk("ovr reset", q, {26'h0, OVR_RST});
    wb(14'hf3f, 1'b0, 32'h0, q);
    chk("unmapped", q, 32'h0);
    // disabled pins sit at the polarity level
    wr(IDX_CTL1, 32'h1c);
    wb(IDX_CTL1, 1'b0, 32'h0, q);
    chk("ctl1 readback", q, 32'h1c);
    chk("off all inverted", {26'h0, pwm_out}, 32'h3f);
    chk("drive disabled", {31'h0, pwm_drive_en}, 32'h0);
    wr(IDX_CTL1, 32'h08);
    wb(IDX_CTL1, 1'b0, 32'h0, q);
    chk("off pair1 inverted", {26'h0, pwm_out}, 32'h0c);
    wr(IDX_CTL1, 32'h00);
    // period 4, duties 2, 0 and above period
    wr(IDX_PER, 32'h3);
    wr(IDX_DUTY0, 32'h2);
    wr(IDX_DUTY0 + 14'h2, 32'h0);
    wr(IDX_DUTY0 + 14'h4, 32'h9);
    // reserved bits 4 and 2 always written as zero
    wr(IDX_CTL0, 32'h8b);
    wb(IDX_STAT, 1'b0, 32'h0, q);
    chk("not yet released", {30'h0, q[1:0]}, 32'h2);
    chk("drive enabled", {31'h0, pwm_drive_en}, 32'h1);
    wait_rel();
    tally(16);
    chk_on({8'h00, 8'h10, 8'h10, 8'h00, 8'h08, 8'h08});
    chk("triggers p4", {24'h0, trig_cnt}, 32'h4);
    wr(IDX_CTL0, 32'hab);
    wb(IDX_CTL0, 1'b0, 32'h0, q);
    chk("align locked", q, 32'h8b);
    // held values ignored until ready
    wr(IDX_CTL0, 32'h89);
    wr(IDX_PER, 32'h7);
    repeat (40) @(posedge core_clk);
    tally(16);
    chk("period kept", {24'h0, trig_cnt}, 32'h4);
    wr(IDX_CTL0, 32'h8b);
    repeat (40) @(posedge core_clk);
    tally(16);
    chk("period 8", {24'h0, trig_cnt}, 32'h2);
    chk("duty in 8", {24'h0, on_cnt[0]}, 32'h4);
    // divide by eight at the next reload: 64 cycles a period
    wr(IDX_CTL1, 32'h03);
    repeat (80) @(posedge core_clk);
    tally(64);
    chk("div8 triggers", {24'h0, trig_cnt}, 32'h1);
    chk("div8 duty", {24'h0, on_cnt[0]}, 32'h10);
    // release bit 0 takes the pins at once
    wr(IDX_CTL0, 32'h0b);
    wb(IDX_STAT, 1'b0, 32'h0, q);
    chk("off pins", {26'h0, pwm_out}, 32'h0);
    tally(16);
    chk_on('0);
    // override: all flagged, then high side of pair 0 only, no triggers
    wr(IDX_OVR, 32'hff);
    wb(IDX_OVR, 1'b0, 32'h0, q);
    chk("ovr width", q, 32'h3f);
    wr(IDX_CTL0, 32'hc3);
    wait_rel();
    tally(64);
    chk_on('0);
    chk("trigger off", {24'h0, trig_cnt}, 32'h0);
    wr(IDX_OVR, 32'h01);
    tally(64);
    chk("ovr hi", {24'h0, on_cnt[0]}, 32'h0);
    chk("ovr lo", {24'h0, on_cnt[1]}, 32'h30);
    // disabled: counter held at zero, pins off
    wr(IDX_CTL0, 32'h00);
    wb(IDX_STAT, 1'b0, 32'h0, q);
    repeat (10) @(posedge core_clk);
    wb(IDX_STAT, 1'b0, 32'h0, q2);
    chk("counter stopped", q2, q);
    chk("pins off", {26'h0, pwm_out}, 32'h0);
    // center aligned, six independent channels, set while disabled
    wr(IDX_OVR, 32'h00);
    wr(IDX_CTL1, 32'h20);
    wr(IDX_DUTY0 + 14'h1, 32'h1);
    wr(IDX_CTL0, 32'ha3);
    wait_rel();
    tally(28);
    chk("center duty", {24'h0, on_cnt[0]}, 32'h6);
    chk("indep low", {24'h0, on_cnt[1]}, 32'h2);
    // external count source, edge aligned pairs: 16 cycles a period
    wr(IDX_CTL0, 32'h00);
    wr(IDX_SRC, 32'h1);
    wr(IDX_CTL1, 32'h00);
    wr(IDX_CTL0, 32'h83);
    wait_rel();
    tally(32);
    chk("ext duty hi", {24'h0, on_cnt[0]}, 32'h8);
    chk("ext duty lo", {24'h0, on_cnt[1]}, 32'h18);
    chk("ext no trigger", {24'h0, trig_cnt}, 32'h0);
    finish_test();
  end
endmodule

`default_nettype wire
